// ---- ddsl_pkg.sv ----
// Shared constants for the serial load port and its host
package ddsl_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CMD_LSB    = 12;
  localparam int unsigned ADDR_LSB   = 8;
  localparam int unsigned SYNC_BIT   = 13;
  localparam int unsigned SELSRC_BIT = 12;
  localparam int unsigned SLEEP_BIT  = 13;
  localparam int unsigned RESET_BIT  = 12;
  localparam int unsigned CLR_BIT    = 11;
  localparam int unsigned FBIT_POS   = 0;
  localparam int unsigned PBIT_LSB   = 1;

  localparam logic [4:0] BIT_CNT_FULL = 5'h10;
  localparam logic [4:0] BIT_CNT_LAST = 5'h0f;
  localparam logic [3:0] BYTE_LAST    = 4'h7;
  localparam logic [3:0] WORD_LAST    = 4'hf;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_LOAD     = 4'h0;
  localparam logic [3:0] CMD_SELBITS  = 4'h1;
  localparam logic [1:0] CMD_SYNC_GRP = 2'h2;
  localparam logic [1:0] CMD_PWR_GRP  = 2'h3;

  // ----------------------------------------------------------------
  // Destination byte map
  // ----------------------------------------------------------------
  localparam int unsigned NUM_DEST   = 16;
  localparam int unsigned FREQ_BASE  = 0;
  localparam int unsigned PHASE_BASE = 8;
  localparam int unsigned NUM_FREQ   = 2;
  localparam int unsigned NUM_PHASE  = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  DEST_RST   = 8'h00;
  localparam logic        SYNC_RST   = 1'h0;
  localparam logic        SELSRC_RST = 1'h0;
  localparam logic        SLEEP_RST  = 1'h0;
  localparam logic        ACCRST_RST = 1'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_HZ        = 50_000_000;
  localparam int unsigned SCLK_MAX_HZ   = 20_000_000;
  localparam int unsigned SCLK_HALF_CYC =
    (SYS_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int unsigned GAP_CYC       = 4;
  localparam logic [3:0]  HALF_LAST     = 4'(SCLK_HALF_CYC - 1);
  localparam logic [3:0]  GAP_LAST      = 4'(GAP_CYC - 1);

endpackage

// ---- ddsl_if.sv ----
// Three-wire load link plus the selection pins
`timescale 1ns/1ps
interface ddsl_if;
  logic sclk;
  logic frame_strobe_n;
  logic serial_data_in;
  logic freq_reg_select;
  logic phase_select_lo;
  logic phase_select_hi;

  modport host (
    output sclk,
    output frame_strobe_n,
    output serial_data_in,
    output freq_reg_select,
    output phase_select_lo,
    output phase_select_hi
  );

  modport device (
    input sclk,
    input frame_strobe_n,
    input serial_data_in,
    input freq_reg_select,
    input phase_select_lo,
    input phase_select_hi
  );
endinterface

// ---- ddsl_device.sv ----
// Serial load port of the synthesizer: shifter, crossing, decode, registers
//
// Contract
// - Frame low carries exactly one 16-bit word.
// - Host shift clock at most 20 MHz.
// - Accept running or resting shift clock.
// - Sample data on falling shift edge.
// - MSB first: command, address, data byte.
// - Byte host keeps frame low across bytes.
// - LSB-first host reverses word bit order.
// - Two frequency registers, chosen by select input.
// - Four phase registers, chosen by two inputs.
// - Active-high frame pulses get inverted by host.
// - Shift clock rests high between byte writes.
// - Completed word loads on third master edge after.
// - Sync bit adds two master cycles latency.
`timescale 1ns/1ps
module ddsl_device (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  ddsl_if.device           link,
  output logic [31:0]      freq_word_q,
  output logic [11:0]      phase_word_q,
  output logic             freq_index_q,
  output logic [1:0]       phase_index_q,
  output logic             sleep_mode_q,
  output logic             accum_reset_q,
  output logic             sync_enabled_q,
  output logic             select_source_q,
  output logic             word_loaded_q,
  output logic [15:0]      last_word_q
);

  // ----------------------------------------------------------------
  // Link domain: shifter on the falling shift edge
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [15:0] link_word_q;
  logic        link_tog_q;
  logic        frame_clr_n;
  logic        shift_en;
  logic        word_done;

  // Frame high holds the counter clear, so a short frame leaves no trace
  assign frame_clr_n = resetn & ~link.frame_strobe_n;
  assign shift_en    = ~link.frame_strobe_n && (bit_cnt_q != ddsl_pkg::BIT_CNT_FULL);
  assign word_done   = shift_en && (bit_cnt_q == ddsl_pkg::BIT_CNT_LAST);

  // Only edges inside a frame matter, so idle clock level is irrelevant
  always_ff @(negedge link.sclk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      bit_cnt_q <= 5'h00;
    end else if (shift_en) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 15'h0000;
    end else if (shift_en) begin
      shift_q <= {shift_q[13:0], link.serial_data_in};
    end
  end

  // Whole word only: the partial shift register is never handed over
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      link_word_q <= 16'h0000;
      link_tog_q  <= 1'h0;
    end else if (word_done) begin
      link_word_q <= {shift_q, link.serial_data_in};
      link_tog_q  <= ~link_tog_q;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the master clock domain
  // ----------------------------------------------------------------
  logic       tog_s1_q;
  logic       tog_s2_q;
  logic       tog_s3_q;
  logic [1:0] ld_pipe_q;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_p1_q;
  logic [2:0] pin_p2_q;
  logic       load_now;
  logic       load_eff;
  logic [2:0] pin_eff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tog_s1_q <= 1'h0;
      tog_s2_q <= 1'h0;
      tog_s3_q <= 1'h0;
    end else begin
      tog_s1_q <= link_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Word register is stable long before and after the toggle arrives
  assign load_now = tog_s2_q ^ tog_s3_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {link.phase_select_hi, link.phase_select_lo, link.freq_reg_select};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Two extra stages used only while the sync bit is set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ld_pipe_q <= 2'h0;
      pin_p1_q  <= 3'h0;
      pin_p2_q  <= 3'h0;
    end else begin
      // Pipe runs only while sync is on, so enabling sync cannot replay a word
      ld_pipe_q <= sync_enabled_q ? {ld_pipe_q[0], load_now} : 2'h0;
      pin_p1_q  <= pin_s2_q;
      pin_p2_q  <= pin_p1_q;
    end
  end

  assign load_eff = sync_enabled_q ? ld_pipe_q[1] : load_now;
  assign pin_eff  = sync_enabled_q ? pin_p2_q : pin_s2_q;

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  logic [3:0] cmd_f;
  logic [3:0] addr_f;
  logic [7:0] data_f;
  logic       is_load;
  logic       is_selbits;
  logic       is_sync;
  logic       is_pwr;

  assign cmd_f      = link_word_q[ddsl_pkg::CMD_LSB +: 4];
  assign addr_f     = link_word_q[ddsl_pkg::ADDR_LSB +: 4];
  assign data_f     = link_word_q[7:0];
  assign is_load    = load_eff && (cmd_f == ddsl_pkg::CMD_LOAD);
  assign is_selbits = load_eff && (cmd_f == ddsl_pkg::CMD_SELBITS);
  assign is_sync    = load_eff && (cmd_f[3:2] == ddsl_pkg::CMD_SYNC_GRP);
  assign is_pwr     = load_eff && (cmd_f[3:2] == ddsl_pkg::CMD_PWR_GRP);

  // ----------------------------------------------------------------
  // Destination bytes: two frequency words, four phase words
  // ----------------------------------------------------------------
  logic [7:0] dest_q [ddsl_pkg::NUM_DEST];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < ddsl_pkg::NUM_DEST; i++) begin
        dest_q[i] <= ddsl_pkg::DEST_RST;
      end
    end else if (is_load) begin
      dest_q[addr_f] <= data_f;
    end
  end

  logic [31:0] freq_reg  [ddsl_pkg::NUM_FREQ];
  logic [11:0] phase_reg [ddsl_pkg::NUM_PHASE];

  for (genvar g = 0; g < ddsl_pkg::NUM_FREQ; g++) begin : g_freq
    localparam int unsigned B = ddsl_pkg::FREQ_BASE + 4 * g;
    assign freq_reg[g] = {dest_q[B + 3], dest_q[B + 2], dest_q[B + 1], dest_q[B]};
  end

  for (genvar g = 0; g < ddsl_pkg::NUM_PHASE; g++) begin : g_phase
    localparam int unsigned B = ddsl_pkg::PHASE_BASE + 2 * g;
    assign phase_reg[g] = {dest_q[B + 1][3:0], dest_q[B]};
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic       fbit_q;
  logic [1:0] pbit_q;
  logic       clr_now;

  assign clr_now = is_pwr && link_word_q[ddsl_pkg::CLR_BIT];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_enabled_q  <= ddsl_pkg::SYNC_RST;
      select_source_q <= ddsl_pkg::SELSRC_RST;
    end else if (clr_now) begin
      sync_enabled_q  <= ddsl_pkg::SYNC_RST;
      select_source_q <= ddsl_pkg::SELSRC_RST;
    end else if (is_sync) begin
      sync_enabled_q  <= link_word_q[ddsl_pkg::SYNC_BIT];
      select_source_q <= link_word_q[ddsl_pkg::SELSRC_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sleep_mode_q  <= ddsl_pkg::SLEEP_RST;
      accum_reset_q <= ddsl_pkg::ACCRST_RST;
    end else if (is_pwr) begin
      sleep_mode_q  <= link_word_q[ddsl_pkg::SLEEP_BIT];
      accum_reset_q <= link_word_q[ddsl_pkg::RESET_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fbit_q <= 1'h0;
      pbit_q <= 2'h0;
    end else if (is_selbits) begin
      fbit_q <= data_f[ddsl_pkg::FBIT_POS];
      pbit_q <= data_f[ddsl_pkg::PBIT_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Selection and outputs
  // ----------------------------------------------------------------
  logic       sel_freq;
  logic [1:0] sel_phase;

  assign sel_freq  = select_source_q ? fbit_q : pin_eff[0];
  assign sel_phase = select_source_q ? pbit_q : pin_eff[2:1];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      freq_word_q   <= 32'h0000_0000;
      phase_word_q  <= 12'h000;
      freq_index_q  <= 1'h0;
      phase_index_q <= 2'h0;
      word_loaded_q <= 1'h0;
    end else begin
      freq_word_q   <= freq_reg[sel_freq];
      phase_word_q  <= phase_reg[sel_phase];
      freq_index_q  <= sel_freq;
      phase_index_q <= sel_phase;
      word_loaded_q <= load_eff;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_word_q <= 16'h0000;
    end else if (load_eff) begin
      last_word_q <= link_word_q;
    end
  end

endmodule

// ---- ddsl_host.sv ----
// Host end: turns command words into framed serial writes
`timescale 1ns/1ps
module ddsl_host (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  ddsl_if.host             link,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  input  wire logic        byte_mode,
  input  wire logic        freq_sel_in,
  input  wire logic [1:0]  phase_sel_in,
  output logic             cmd_ready_q
);

  typedef enum logic [2:0] {
    DDSL_IDLE,
    DDSL_SETUP,
    DDSL_LOW,
    DDSL_GAP,
    DDSL_DONE
  } ddsl_hstate_t;

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  ddsl_hstate_t state_q;
  logic [3:0]   tmr_q;
  logic [3:0]   bit_q;
  logic [15:0]  shreg_q;
  logic         sclk_q;
  logic         fs_n_q;
  logic         sd_q;
  logic         half_up;
  logic         gap_up;
  logic         take;

  assign half_up = (tmr_q == ddsl_pkg::HALF_LAST);
  assign gap_up  = (tmr_q == ddsl_pkg::GAP_LAST);
  assign take    = cmd_valid && cmd_ready_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q     <= DDSL_IDLE;
      tmr_q       <= 4'h0;
      bit_q       <= 4'h0;
      shreg_q     <= 16'h0000;
      sclk_q      <= 1'h1;
      fs_n_q      <= 1'h1;
      sd_q        <= 1'h0;
      cmd_ready_q <= 1'h1;
    end else begin
      case (state_q)
        DDSL_IDLE: begin
          if (take) begin
            shreg_q     <= cmd_word;
            sd_q        <= cmd_word[15];
            fs_n_q      <= 1'h0;
            bit_q       <= 4'h0;
            tmr_q       <= 4'h0;
            cmd_ready_q <= 1'h0;
            state_q     <= DDSL_SETUP;
          end
        end
        DDSL_SETUP: begin
          tmr_q <= tmr_q + 4'h1;
          if (half_up) begin
            tmr_q   <= 4'h0;
            sclk_q  <= 1'h0;
            state_q <= DDSL_LOW;
          end
        end
        DDSL_LOW: begin
          tmr_q <= tmr_q + 4'h1;
          if (half_up) begin
            tmr_q   <= 4'h0;
            sclk_q  <= 1'h1;
            bit_q   <= bit_q + 4'h1;
            shreg_q <= {shreg_q[14:0], 1'h0};
            sd_q    <= shreg_q[14];
            if (bit_q == ddsl_pkg::WORD_LAST) begin
              state_q <= DDSL_DONE;
            end else if (byte_mode && (bit_q == ddsl_pkg::BYTE_LAST)) begin
              state_q <= DDSL_GAP;
            end else begin
              state_q <= DDSL_SETUP;
            end
          end
        end
        DDSL_GAP: begin
          // Frame stays low, clock rests high between the two bytes
          tmr_q <= tmr_q + 4'h1;
          if (gap_up) begin
            tmr_q   <= 4'h0;
            state_q <= DDSL_SETUP;
          end
        end
        DDSL_DONE: begin
          tmr_q <= tmr_q + 4'h1;
          if (half_up) begin
            tmr_q       <= 4'h0;
            fs_n_q      <= 1'h1;
            cmd_ready_q <= 1'h1;
            state_q     <= DDSL_IDLE;
          end
        end
        default: begin
          state_q <= DDSL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Selection pins
  // ----------------------------------------------------------------
  logic       fsel_q;
  logic [1:0] psel_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fsel_q <= 1'h0;
      psel_q <= 2'h0;
    end else begin
      fsel_q <= freq_sel_in;
      psel_q <= phase_sel_in;
    end
  end

  assign link.sclk            = sclk_q;
  assign link.frame_strobe_n  = fs_n_q;
  assign link.serial_data_in  = sd_q;
  assign link.freq_reg_select = fsel_q;
  assign link.phase_select_lo = psel_q[0];
  assign link.phase_select_hi = psel_q[1];

endmodule

// ---- ddsl_chk.sv ----
// Checker on the load link wires
`timescale 1ns/1ps
module ddsl_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic frame_strobe_n,
  input wire logic serial_data_in
);
  // ----------------------------------------------------------------
  // Falling-edge count within a frame
  // ----------------------------------------------------------------
  logic       sclk_q;
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  wire        sclk_fall = sclk_q & ~sclk;

  assign fall_cnt_d = frame_strobe_n ? 5'h00 : fall_cnt_q + {4'h0, sclk_fall};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q     <= 1'b1;
      fall_cnt_q <= 5'h00;
    end else begin
      sclk_q     <= sclk;
      fall_cnt_q <= fall_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_sclk_half;
    $changed(sclk) |=> $stable(sclk);
  endproperty
  a_sclk_half: assert property (p_sclk_half)
    else $error("shift clock half period too short");

  property p_data_rise;
    (!frame_strobe_n && !$past(frame_strobe_n) && $changed(serial_data_in)) |-> $rose(sclk);
  endproperty
  a_data_rise: assert property (p_data_rise)
    else $error("data changed away from a rising shift edge");

  property p_data_fall;
    ($fell(sclk) && !frame_strobe_n) |-> $stable(serial_data_in);
  endproperty
  a_data_fall: assert property (p_data_fall)
    else $error("data moved on a falling shift edge");

  property p_frame_edges;
    $changed(frame_strobe_n) |-> sclk && $stable(sclk);
  endproperty
  a_frame_edges: assert property (p_frame_edges)
    else $error("frame moved while shift clock not resting high");

  property p_idle;
    (frame_strobe_n && $past(frame_strobe_n)) |-> sclk;
  endproperty
  a_idle: assert property (p_idle)
    else $error("shift clock low outside a frame");

  property p_word_count;
    $rose(frame_strobe_n) |-> fall_cnt_q == 5'h10;
  endproperty
  a_word_count: assert property (p_word_count)
    else $error("frame did not carry sixteen falling edges");

  property p_frame_len;
    $fell(frame_strobe_n) |-> ##[60:80] $rose(frame_strobe_n);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame length out of range");

  property p_first_setup;
    $fell(frame_strobe_n) |-> sclk[*2];
  endproperty
  a_first_setup: assert property (p_first_setup)
    else $error("first bit not set up before shift clock fell");

  property p_byte_hold;
    (fall_cnt_q == 5'h08 && sclk) |-> !frame_strobe_n;
  endproperty
  a_byte_hold: assert property (p_byte_hold)
    else $error("frame released after only eight bits");

  c_frame_done: cover property ($rose(frame_strobe_n));
  c_byte_gap: cover property ((fall_cnt_q == 5'h08 && sclk)[*5]);
  c_idle: cover property (frame_strobe_n[*8]);
endmodule

// ---- tb.sv ----
// Testbench: host and device back to back, plus a hand-driven link
`timescale 1ns/1ps
module tb;
  logic        sys_clk;
  logic        resetn;
  logic        cmd_valid;
  logic [15:0] cmd_word;
  logic        byte_mode;
  logic        freq_sel_in;
  logic [1:0]  phase_sel_in;
  logic        cmd_ready_q;
  logic [31:0] freq_word_q;
  logic [11:0] phase_word_q;
  logic        freq_index_q;
  logic [1:0]  phase_index_q;
  logic        sleep_mode_q;
  logic        accum_reset_q;
  logic        sync_enabled_q;
  logic        select_source_q;
  logic        word_loaded_q;
  logic [15:0] last_word_q;
  logic [31:0] freq2_q;
  logic        loaded2_q;
  logic [15:0] last2_q;
  logic [15:0] cap_q = 16'h0000;
  int          cap_n = 0;
  int          ld2_n = 0;
  int          lat;
  int          err_count;
  int          cmp_count;

  ddsl_if link ();
  ddsl_if link2 ();

  ddsl_host i_ddsl_host (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .link         (link),
    .cmd_valid    (cmd_valid),
    .cmd_word     (cmd_word),
    .byte_mode    (byte_mode),
    .freq_sel_in  (freq_sel_in),
    .phase_sel_in (phase_sel_in),
    .cmd_ready_q  (cmd_ready_q)
  );

  ddsl_device i_ddsl_device (
    .sys_clk(sys_clk), .resetn(resetn), .link(link),
    .freq_word_q(freq_word_q), .phase_word_q(phase_word_q),
    .freq_index_q(freq_index_q), .phase_index_q(phase_index_q),
    .sleep_mode_q(sleep_mode_q), .accum_reset_q(accum_reset_q),
    .sync_enabled_q(sync_enabled_q), .select_source_q(select_source_q),
    .word_loaded_q(word_loaded_q), .last_word_q(last_word_q)
  );

  ddsl_device i_ddsl_device_2 (
    .sys_clk(sys_clk), .resetn(resetn), .link(link2),
    .freq_word_q(freq2_q), .phase_word_q(), .freq_index_q(), .phase_index_q(),
    .sleep_mode_q(), .accum_reset_q(), .sync_enabled_q(), .select_source_q(),
    .word_loaded_q(loaded2_q), .last_word_q(last2_q)
  );

  ddsl_chk i_ddsl_chk (
    .sys_clk        (sys_clk),
    .resetn         (resetn),
    .sclk           (link.sclk),
    .frame_strobe_n (link.frame_strobe_n),
    .serial_data_in (link.serial_data_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Wire monitors
  // ----------------------------------------------------------------
  // Frame falls while the shift clock rests high, so a high clock marks a new frame
  always @(negedge link.sclk or negedge link.frame_strobe_n) begin
    if (link.sclk === 1'b1) begin
      cap_n <= 0;
    end else if (link.frame_strobe_n === 1'b0) begin
      cap_q <= {cap_q[14:0], link.serial_data_in};
      cap_n <= cap_n + 1;
    end
  end
  always @(negedge sys_clk) begin
    if (loaded2_q === 1'b1) begin
      ld2_n <= ld2_n + 1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    err_count++;
    $display("BAD %0t wait for %s ran out", $time, what);
    finish_test();
  endtask

  task automatic settle();
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 200) hang("ready");
    end
  endtask

  task automatic send(input logic [15:0] w, input logic bm);
    wait_ready();
    cmd_word  = w;
    byte_mode = bm;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    lat = 1;
    while (word_loaded_q !== 1'b1) begin
      @(negedge sys_clk);
      lat++;
      if (lat > 300) hang("load");
    end
    check(last_word_q, w, "applied word");
    check(cap_q, w, "bits on wire");
    check(cap_n, 16, "falls in frame");
    wait_ready();
    check({link.sclk, link.frame_strobe_n}, 2'h3, "idle levels");
  endtask

  // Hand driver for the second link, 48 ns shift period
  task automatic drv(input logic [15:0] w, input int nb, input logic rest);
    repeat (4) #24 link2.sclk = ~link2.sclk;
    link2.frame_strobe_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      link2.sclk = 1'b1;
      link2.serial_data_in = w[4'(15 - i)];
      #24 link2.sclk = 1'b0;
      #24;
    end
    link2.sclk = rest;
    #24 link2.frame_strobe_n = 1'b1;
    link2.serial_data_in = ~link2.serial_data_in;
    #24;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({freq_word_q, phase_word_q, last_word_q}, 32'h0, "reset regs");
    check({cmd_ready_q, link.sclk, link.frame_strobe_n}, 3'h7, "reset link");
  endtask

  task automatic t_freq();
    for (int i = 0; i < 4; i++) send({4'h0, 4'(i), 8'(8'h11 * (4 - i))}, 1'b0);
    for (int i = 0; i < 4; i++) send({4'h0, 4'(i + 4), 8'(8'ha0 + i)}, 1'b1);
    settle();
    check(freq_word_q, 32'h11223344, "freq0");
    freq_sel_in = 1'b1;
    settle();
    check({freq_index_q, freq_word_q}, 33'h1a3a2a1a0, "freq1");
  endtask

  task automatic t_phase();
    for (int k = 0; k < 4; k++) begin
      send({4'h0, 4'(8 + 2 * k), 8'(8'h10 + k)}, 1'b0);
      send({4'h0, 4'(9 + 2 * k), 8'(k + 1)}, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      phase_sel_in = 2'(k);
      settle();
      check({phase_index_q, phase_word_q}, {2'(k), 4'(k + 1), 8'(8'h10 + k)}, "phase");
    end
  endtask

  task automatic t_ctrl();
    int lat_a;
    send(16'h9000, 1'b0);
    check(select_source_q, 1'b1, "selsrc");
    freq_sel_in  = 1'b0;
    phase_sel_in = 2'h0;
    send(16'h1003, 1'b0);
    settle();
    check({freq_index_q, phase_index_q}, 3'h5, "bit selects");
    send(16'h1000, 1'b0);
    lat_a = lat;
    send(16'hb000, 1'b0);
    check(sync_enabled_q, 1'b1, "sync");
    send(16'h1000, 1'b0);
    check(lat - lat_a, 2, "sync latency");
    send(16'hf000, 1'b0);
    check({sleep_mode_q, accum_reset_q, sync_enabled_q}, 3'h7, "power");
    send(16'hc800, 1'b0);
    check({sleep_mode_q, accum_reset_q, sync_enabled_q, select_source_q}, 4'h0, "clear");
    send(16'h5123, 1'b0);
    settle();
    check(freq_word_q, 32'h11223344, "ignored cmd");
  endtask

  task automatic t_link2();
    @(negedge sys_clk);
    #7;
    drv(16'h0255, 8, 1'b1);
    settle();
    check({ld2_n, last2_q}, 48'h0, "short frame");
    drv(16'h0034, 17, 1'b0);
    drv(16'h0156, 16, 1'b1);
    settle();
    check(freq2_q, 32'h00005634, "dev2 freq");
    check({ld2_n, last2_q}, 48'h2_0156, "dev2 words");
  endtask

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    byte_mode = 1'b0;
    freq_sel_in = 1'b0;
    phase_sel_in = 2'h0;
    err_count = 0;
    cmp_count = 0;
    lat = 0;
    link2.sclk = 1'b1;
    link2.frame_strobe_n = 1'b1;
    link2.serial_data_in = 1'b0;
    link2.freq_reg_select = 1'b0;
    link2.phase_select_lo = 1'b0;
    link2.phase_select_hi = 1'b0;
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_freq();
    t_phase();
    t_ctrl();
    t_link2();
    finish_test();
  end
endmodule
